// File: design/sbsc_pkg.sv
// Package with widths, encodings and reset values of the burst memory front end.
package sbsc_pkg;
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int BYTE_W = 9;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int DEPTH = 16;
  localparam int IDX_W = 4;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  typedef enum logic [2:0] {
    SBSC_IDLE = 3'h1,
    SBSC_READ = 3'h2,
    SBSC_WRITE = 3'h4
  } sbsc_state_t;
endpackage

// File: design/sbsc_burst_cnt.sv
// Two-bit burst counter with linear and interleaved address order.
module sbsc_burst_cnt
  import sbsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic advance,
  input wire logic linear,
  input wire logic [1:0] start,
  output logic [1:0] low_bits
);
  logic [1:0] start_q;
  logic [1:0] count_q;
  logic [1:0] count_d;

  // The count wraps in two bits, so the burst stays inside its group of four.
  function automatic logic [1:0] burst_addr(input logic [1:0] s,
    input logic [1:0] c, input logic lin);
    burst_addr = lin ? 2'(s + c) : (s ^ c); // RULE15
  endfunction

  // An advancing cycle already uses the stepped address, not the old one.
  assign count_d = advance ? 2'(count_q + CNT_ONE) : count_q; // RULE6 RULE12

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= CNT_RST;
      count_q <= CNT_RST;
    end
    else if (load)
    begin
      start_q <= start; // RULE2
      count_q <= CNT_RST;
    end
    else if (advance)
    begin
      count_q <= count_d; // RULE6 RULE12
    end
  end

  assign low_bits = burst_addr(start_q, count_d, linear);
endmodule

// File: design/sbsc_front_end.sv
// Synchronous control front end of a pipelined burst static memory.
// Notes on behaviour
// RULE1 - Address taken on strobe with chip selected.
// RULE2 - New address loads low two bits into counter.
// RULE3 - Byte selects write only with byte enable.
// RULE4 - Global write writes all lanes.
// RULE5 - Controller drives byte enable for partial writes.
// RULE6 - Counter advances when advance sampled low.
// RULE7 - First select high masks processor strobe.
// RULE8 - Second chip select is active high.
// RULE9 - Third chip select is active low.
// RULE10 - Selects sampled only on address loads.
// RULE11 - Both strobes low: processor strobe wins.
// RULE12 - Advance steps to next burst address.
// RULE13 - Static strap picks linear or interleaved.
// RULE14 - Read data appears one edge later.
// RULE15 - Counter wraps in four-word group.
// RULE16 - Write when global or enabled byte low.
module sbsc_front_end
  import sbsc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [sbsc_pkg::ADDR_W-1:0] ADDR,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic CHIP_SEL1_N,
  input wire logic CHIP_SEL2,
  input wire logic CHIP_SEL3_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WR_ENABLE_N,
  input wire logic [sbsc_pkg::LANES-1:0] BYTE_LANE_SELECT_N,
  input wire logic BURST_ORDER,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [sbsc_pkg::DATA_W-1:0] DATA_IN,
  output logic [sbsc_pkg::DATA_W-1:0] DATA_OUT,
  output logic [sbsc_pkg::DATA_W-1:0] DATA_OE,
  output logic [sbsc_pkg::ADDR_W-1:0] ACCESS_ADDR,
  output logic SELECTED,
  output logic WRITE_CYCLE,
  output logic [sbsc_pkg::LANES-1:0] LANE_WRITE
);
  import sbsc_pkg::*;

  logic proc_strobe;
  logic ctrl_strobe;
  logic selected;
  logic load;
  logic advance;
  logic [LANES-1:0] lanes;
  logic wr_any;
  logic [1:0] low_bits;
  logic linear_q;
  logic order_taken_q;
  logic [ADDR_W-1:0] addr_q;
  logic sel_q;
  sbsc_state_t state_q;
  sbsc_state_t state_d;
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [ADDR_W-1:0] cur_addr;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wr_word;

  function automatic logic [LANES-1:0] lane_mask(input logic gw_n,
    input logic bwe_n, input logic [LANES-1:0] bw_n);
    if (!gw_n)
      lane_mask = LANES_ALL; // RULE4
    else if (!bwe_n)
      lane_mask = ~bw_n; // RULE3 RULE5
    else
      lane_mask = LANES_NONE;
  endfunction

  assign selected = !CHIP_SEL1_N && CHIP_SEL2 && !CHIP_SEL3_N; // RULE8 RULE9
  // The processor strobe has no effect while the first select is high.
  assign proc_strobe = !PROCESSOR_ADDR_STROBE_N && !CHIP_SEL1_N; // RULE7
  // A processor strobe pre-empts the controller strobe on the same edge.
  assign ctrl_strobe = !CONTROLLER_ADDR_STROBE_N && !proc_strobe; // RULE11
  assign load = (proc_strobe || ctrl_strobe) && selected; // RULE1 RULE10
  assign advance = !load && !BURST_ADVANCE_N && sel_q; // RULE6 RULE12
  assign lanes = lane_mask(GLOBAL_WRITE_N, BYTE_WR_ENABLE_N,
    BYTE_LANE_SELECT_N);
  assign wr_any = |lanes; // RULE16

  // The strap is caught once after reset and held, since it must not move.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      linear_q <= 1'b0;
      order_taken_q <= 1'b0;
    end
    else if (!order_taken_q)
    begin
      linear_q <= !BURST_ORDER; // RULE13
      order_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_q <= ADDR_RST;
      sel_q <= 1'b0;
    end
    else if (load)
    begin
      addr_q <= ADDR; // RULE1
      sel_q <= 1'b1;
    end
    else if ((!PROCESSOR_ADDR_STROBE_N && !CHIP_SEL1_N)
      || !CONTROLLER_ADDR_STROBE_N)
    begin
      sel_q <= 1'b0; // A strobe with a deselect ends the burst.
    end
  end

  sbsc_burst_cnt sbsc_burst_cnt_inst (
    .clk(MCLK),
    .rst_n(RST_N),
    .load(load),
    .advance(advance),
    .linear(linear_q),
    .start(ADDR[1:0]),
    .low_bits(low_bits)
  );

  // Address of the current cycle: the fresh one on a load, else the burst.
  assign cur_addr = load ? ADDR : {addr_q[ADDR_W-1:2], low_bits};
  assign idx = cur_addr[IDX_W-1:0];

  always_comb
  begin
    wr_word = mem_q[idx];
    for (int i = 0; i < LANES; i++)
      if (lanes[i])
        wr_word[i*BYTE_W +: BYTE_W] = DATA_IN[i*BYTE_W +: BYTE_W];
  end

  always_comb
  begin
    state_d = SBSC_IDLE;
    // A masked processor strobe leaves the running burst going.
    if (load || (sel_q && !proc_strobe && CONTROLLER_ADDR_STROBE_N)) // RULE7
      state_d = wr_any ? SBSC_WRITE : SBSC_READ; // RULE16
  end

  // The storage array is a small model so the read pipeline can be seen.
  always_ff @(posedge MCLK)
  begin
    if (state_d == SBSC_WRITE)
      mem_q[idx] <= wr_word; // RULE3 RULE4
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= SBSC_IDLE;
      DATA_OUT <= DATA_RST;
      DATA_OE <= DATA_RST;
      ACCESS_ADDR <= ADDR_RST;
      SELECTED <= 1'b0;
      WRITE_CYCLE <= 1'b0;
      LANE_WRITE <= LANES_NONE;
    end
    else
    begin
      state_q <= state_d;
      ACCESS_ADDR <= cur_addr;
      SELECTED <= state_d != SBSC_IDLE;
      WRITE_CYCLE <= state_d == SBSC_WRITE;
      LANE_WRITE <= (state_d == SBSC_WRITE) ? lanes : LANES_NONE;
      case (state_d)
        SBSC_READ:
        begin
          DATA_OUT <= mem_q[idx]; // RULE14
          DATA_OE <= {DATA_W{!OUTPUT_ENABLE_N}};
        end
        SBSC_WRITE:
        begin
          DATA_OUT <= DATA_OUT;
          DATA_OE <= DATA_RST;
        end
        default:
        begin
          DATA_OUT <= DATA_OUT;
          DATA_OE <= DATA_RST;
        end
      endcase
    end
  end

  sequence load_seq;
    load;
  endsequence

  property load_captures_p;
    @(posedge MCLK) disable iff (!RST_N)
      load_seq |=> ACCESS_ADDR == $past(ADDR);
  endproperty

  addr_capture_a: assert property (load_captures_p) // RULE1 RULE2
    else $error("Loaded address not presented.");
  global_write_a: assert property ( // RULE4
    @(posedge MCLK) disable iff (!RST_N)
    load && !GLOBAL_WRITE_N |=> LANE_WRITE == LANES_ALL)
    else $error("Global write missed a lane.");
  byte_qual_a: assert property ( // RULE3
    @(posedge MCLK) disable iff (!RST_N)
    load && GLOBAL_WRITE_N && BYTE_WR_ENABLE_N |=> !WRITE_CYCLE)
    else $error("Byte write without byte enable.");
  cs1_mask_a: assert property ( // RULE7
    @(posedge MCLK) disable iff (!RST_N)
    CHIP_SEL1_N && CONTROLLER_ADDR_STROBE_N |-> !load)
    else $error("Processor strobe honoured while deselected.");
  cs_combine_a: assert property ( // RULE8 RULE9
    @(posedge MCLK) disable iff (!RST_N)
    load |-> CHIP_SEL2 && !CHIP_SEL3_N)
    else $error("Load with a select inactive.");
  burst_step_a: assert property ( // RULE6 RULE12
    @(posedge MCLK) disable iff (!RST_N)
    advance && linear_q && $stable(linear_q)
      |=> ACCESS_ADDR[1:0] != $past(ACCESS_ADDR[1:0]) || $past(load))
    else $error("Burst did not step.");
  read_pipe_a: assert property ( // RULE14
    @(posedge MCLK) disable iff (!RST_N)
    state_d == SBSC_READ |=> DATA_OUT == mem_q[ACCESS_ADDR[IDX_W-1:0]])
    else $error("Read data not one edge late.");
  write_kind_a: assert property ( // RULE16
    @(posedge MCLK) disable iff (!RST_N)
    load && !BYTE_WR_ENABLE_N && GLOBAL_WRITE_N
      && BYTE_LANE_SELECT_N == LANES_ALL |=> !WRITE_CYCLE)
    else $error("Write without any lane.");
  write_lanes_a: assert property ( // RULE16
    @(posedge MCLK) disable iff (!RST_N)
    state_q == SBSC_WRITE |-> LANE_WRITE != LANES_NONE && WRITE_CYCLE)
    else $error("Write state without a written lane.");
endmodule

// File: sim/sbsc_cpu_model.sv
// Processor bus model that drives the burst memory front end.
module sbsc_cpu_model
  import sbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] addr = ADDR_RST;
  logic [DATA_W-1:0] wdata = DATA_RST;
  logic [7:0] ctl = 8'h57;
  logic [LANES-1:0] bw_n = LANES_ALL;
  // Called after the falling edge so address and controls settle
  // a half period before the capturing rising edge.
  task automatic drive(input logic [7:0] c, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       input logic [LANES-1:0] b);
    addr = a;
    wdata = d;
    ctl = c;
    bw_n = b;
  endtask
endmodule

// File: sim/sbsc_front_end_bench.sv
// Self-checking bench of the burst memory front end.
module sbsc_front_end_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sbsc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic burst_order = 1'b0;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_oe;
  logic [ADDR_W-1:0] access_addr;
  logic selected;
  logic write_cycle;
  logic [LANES-1:0] lane_write;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] a;
  logic [LANES-1:0] lanes;
  logic [1:0] cnt;
  logic act;
  int n_errors = 0;
  int checked = 0;
  int seed = 83;
  sbsc_cpu_model cpu_inst ();
  sbsc_front_end sbsc_front_end_inst (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(cpu_inst.addr),
    .PROCESSOR_ADDR_STROBE_N(cpu_inst.ctl[0]),
    .CONTROLLER_ADDR_STROBE_N(cpu_inst.ctl[1]),
    .BURST_ADVANCE_N(cpu_inst.ctl[2]), .GLOBAL_WRITE_N(cpu_inst.ctl[3]),
    .BYTE_WR_ENABLE_N(cpu_inst.ctl[4]), .CHIP_SEL1_N(cpu_inst.ctl[5]),
    .CHIP_SEL2(cpu_inst.ctl[6]), .CHIP_SEL3_N(cpu_inst.ctl[7]),
    .BYTE_LANE_SELECT_N(cpu_inst.bw_n), .BURST_ORDER(burst_order),
    .OUTPUT_ENABLE_N(1'b0), .DATA_IN(cpu_inst.wdata), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .ACCESS_ADDR(access_addr), .SELECTED(selected),
    .WRITE_CYCLE(write_cycle), .LANE_WRITE(lane_write));
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; the model follows the same edge as the design.
  task automatic cycle(input logic [7:0] c, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] d,
                       input logic [LANES-1:0] b);
    @(negedge mclk);
    cpu_inst.drive(c, ad, d, b);
    @(posedge mclk);
    if ((!c[0] && !c[5]) || !c[1])
    begin
      act = (c[7:5] == 3'h2);
      base = ad;
      cnt = 2'h0;
    end
    else if (act && !c[2])
      cnt = cnt + 2'h1;
    a = base;
    a[1:0] = burst_order ? base[1:0] ^ cnt : base[1:0] + cnt;
    lanes = !c[3] ? LANES_ALL : (!c[4] ? ~b : LANES_NONE);
    #1;
    check(selected, act);
    if (act)
    begin
      check(access_addr, a);
      check(lane_write, lanes);
      check(write_cycle, lanes != LANES_NONE);
      if (lanes == LANES_NONE)
      begin
        check(data_out, mem[a[3:0]]);
        check(data_oe, {DATA_W{1'b1}});
      end
      else
        check(data_oe, DATA_RST);
      for (int i = 0; i < LANES; i++)
        if (lanes[i])
          mem[a[3:0]][BYTE_W*i+:BYTE_W] = d[BYTE_W*i+:BYTE_W];
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Both strap settings need a reset, since the strap is caught only
  // at the first edge after release.
  initial
  begin
    logic [31:0] r;
    for (int o = 0; o < 2; o++)
    begin
      @(negedge mclk);
      rst_n = 1'b0;
      burst_order = o[0];
      act = 1'b0;
      // No strobe may linger from the last run into the edges after release.
      cpu_inst.drive(8'h57, ADDR_RST, DATA_RST, LANES_ALL);
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      for (int i = 0; i < DEPTH; i++)
        cycle(8'h55, i[ADDR_W-1:0], {$random(seed), 4'h0}, LANES_ALL);
      repeat (400)
      begin
        r = $random(seed);
        r[7:5] = (r[7:5] == 3'h0) ? r[10:8] : 3'h2;
        cycle(r[7:0], ADDR_W'($random(seed)), {$random(seed), r[14:11]},
              r[18:15]);
      end
      $display("Test with burst order %0d done", o);
    end
    tally_and_finish();
  end
endmodule
